/* File: rtl/mor_regs.sv */
// Purpose: Operational register bank of an 8-bit microcontroller core.
// Assumes: Core presents one register access per cycle on core_clk.
// Notes:   Read data is registered; it appears the cycle after rd_en, one cycle later for segment and indirect reads.
//
// Notes on behaviour
// - Status bits 6:5 choose one of four 2K program pages.
// - Program counter rewrites load page bits into PC bits 11 and 12.
// - Returns leave page bits alone; stack restores full address.
// - Timeout flag set by sleep, watchdog clear, power-up; cleared by timeout.
// - Power-down flag set at power-on and watchdog clear; cleared by sleep.
// - Timeout/power-down pairs encode wake cause: 00,01,10,11.
// - Status bit2 zero, bit1 nibble carry, bit0 carry; bit7 unused.
// - Bank pointer bits 7:6 choose one of four data banks.
// - Bank pointer bits 5:0 address 64 indirect registers; else plain.
// - Port 5 bits 7:4 are pin data, direction from its control.
// - Port 5 bit 0 selects control register page; bits 3:1 unused.
// - Ports 6,7,8 have full 8-bit data, per-bit direction.
// - Display bits 6:5 select half, third or quarter duty.
// - Display bit 4 low disables and grounds the segment data.
// - Display bit 2 selects waveform A or B; bit 3 unused.
// - Display bits 1:0 pick frame divisor per duty.
// - Data buffer bits 3:0 carry segment data per common line.
// - Counter enable bits 3:0 start or stop four counters.
// - Address 00h accesses the register the bank pointer selects.
`timescale 1ns/1ps
`default_nettype none
module mor_regs (
  input  wire logic       core_clk,      // 125 MHz core clock.
  input  wire logic       resetn,        // Synchronous reset, active low.
  input  wire logic       power_up,      // Pulse: power-on event.
  input  wire logic       reset_pin_wake, // Pulse: reset pin woke sleep.
  input  wire logic       wr_en,         // Register write strobe.
  input  wire logic       rd_en,         // Register read strobe.
  input  wire logic [7:0] addr,          // Register address.
  input  wire logic [7:0] wdata,         // Write data.
  output logic      [7:0] rdata,         // Registered read data.
  output logic      [7:0] ext_addr,      // Banked address for RAM.
  output logic            ext_rd,        // Read passed to banked RAM.
  output logic            ext_wr,        // Write passed to banked RAM.
  output logic      [7:0] ext_wdata,     // Data for banked RAM.
  input  wire logic [7:0] ext_rdata,     // Banked RAM read data.
  input  wire logic       alu_we,        // Flag update from ALU.
  input  wire logic [2:0] alu_flags,     // Zero, nibble carry, carry.
  input  wire logic       sleep_instruction,          // Pulse.
  input  wire logic       watchdog_clear_instruction, // Pulse.
  input  wire logic       watchdog_timeout,           // Pulse.
  input  wire logic       pc_load,       // Jump, call or PC move.
  input  wire logic       pc_return,     // Any return flavour.
  input  wire logic [1:0] page_instr,    // PAGE instruction value.
  input  wire logic       page_instr_en, // PAGE instruction strobe.
  input  wire logic [1:0] bank_instr,    // BANK instruction value.
  input  wire logic       bank_instr_en, // BANK instruction strobe.
  output logic      [1:0] pc_page_bits,  // PC bits 12:11 on a load.
  output logic            pc_page_load,  // Pulse: load pc_page_bits.
  output logic      [1:0] ram_bank_select,   // Active data bank.
  input  wire logic [7:0] port5_pins,    // Port 5 pin levels.
  input  wire logic [7:0] port6_pins,    // Port 6 pin levels.
  input  wire logic [7:0] port7_pins,    // Port 7 pin levels.
  input  wire logic [7:0] port8_pins,    // Port 8 pin levels.
  input  wire logic [3:0] port5_direction_control, // 1 means input.
  input  wire logic [7:0] port6_direction_control, // 1 means input.
  input  wire logic [7:0] port7_direction_control, // 1 means input.
  input  wire logic [7:0] port8_direction_control, // 1 means input.
  output logic      [3:0] port5_out,     // Port 5 output data.
  output logic      [3:0] port5_oe,      // Port 5 drive enables.
  output logic      [7:0] port6_out,     // Port 6 output data.
  output logic      [7:0] port6_oe,      // Port 6 drive enables.
  output logic      [7:0] port7_out,     // Port 7 output data.
  output logic      [7:0] port7_oe,      // Port 7 drive enables.
  output logic      [7:0] port8_out,     // Port 8 output data.
  output logic      [7:0] port8_oe,      // Port 8 drive enables.
  output logic            control_page_select, // Control page.
  output logic            bias_select,   // 0 half, 1 third.
  output logic      [1:0] duty_select,   // Duty code.
  output logic            display_enable, // Display running.
  output logic            waveform_type, // 0 type A, 1 type B.
  output logic      [9:0] frame_divisor, // Sub-clock frame divisor.
  output logic            low_pulse_timer_enable,  // Timer enable.
  output logic            high_pulse_timer_enable, // Timer enable.
  output logic            counter_two_enable,      // Counter enable.
  output logic            counter_one_enable,      // Counter enable.
  input  wire logic [4:0] scan_addr,     // Display scan segment.
  output logic      [3:0] scan_data      // Segment data to driver.
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] core_status_flags;
  logic [7:0] indirect_bank_pointer;
  logic [7:0] port5_data_page_select;
  logic [7:0] port6_data;
  logic [7:0] port7_data;
  logic [7:0] port8_data;
  logic [7:0] display_control;
  logic [7:0] display_segment_address;
  logic [7:0] counter_enables;
  logic [7:0] next_rdata;
  logic [3:0] seg_rdata;
  logic       indirect;
  logic       wr_hit;
  logic       rd_local;

  // Address 00h goes out to the banked RAM at the pointer.
  assign indirect = (addr == mor_pkg::ADDR_INDIRECT);
  assign wr_hit   = wr_en & ~indirect;
  assign rd_local = rd_en & ~indirect;

  // Merges pin levels for input bits with latched data for output bits.
  function automatic logic [7:0] port_read(input logic [7:0] latch,
                                           input logic [7:0] pins,
                                           input logic [7:0] dir);
    port_read = (pins & dir) | (latch & ~dir);
  endfunction

  // Picks the frame base count for a rate code and duty code.
  function automatic logic [8:0] frame_base(input logic [1:0] rate,
                                            input logic [1:0] duty);
    logic [8:0] b;
    b = mor_pkg::DIV_Q0;
    if (duty == 2'(mor_pkg::MOR_DUTY_HALF)) begin
      unique case (rate)
        2'h0: b = mor_pkg::DIV_H0;
        2'h1: b = mor_pkg::DIV_H1;
        2'h2: b = mor_pkg::DIV_H2;
        2'h3: b = mor_pkg::DIV_H3;
      endcase
    end else if (duty == 2'(mor_pkg::MOR_DUTY_THIRD)) begin
      unique case (rate)
        2'h0: b = mor_pkg::DIV_T0;
        2'h1: b = mor_pkg::DIV_T1;
        2'h2: b = mor_pkg::DIV_T2;
        2'h3: b = mor_pkg::DIV_T3;
      endcase
    end else begin
      unique case (rate)
        2'h0: b = mor_pkg::DIV_Q0;
        2'h1: b = mor_pkg::DIV_Q1;
        2'h2: b = mor_pkg::DIV_Q2;
        2'h3: b = mor_pkg::DIV_Q3;
      endcase
    end
    frame_base = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Page bits, hardware flags and arithmetic flags of the status register.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      core_status_flags <= mor_pkg::RST_ZERO;
      core_status_flags[mor_pkg::ST_TO] <= 1'b1;
      core_status_flags[mor_pkg::ST_PD] <= 1'b1;
    end else begin
      if (wr_hit && addr == mor_pkg::ADDR_STATUS) begin
        core_status_flags <= (wdata & mor_pkg::MASK_STATUS_SW)
          | (core_status_flags & ~mor_pkg::MASK_STATUS_SW);
      end else if (alu_we) begin
        core_status_flags[2:0] <= alu_flags;
      end
      if (page_instr_en) begin
        core_status_flags[6:5] <= page_instr;
      end
      // Returns do not touch the page field.
      if (power_up || reset_pin_wake) begin
        core_status_flags[mor_pkg::ST_TO] <= 1'b1;
        core_status_flags[mor_pkg::ST_PD] <= power_up;
      end else if (watchdog_timeout) begin
        core_status_flags[mor_pkg::ST_TO] <= 1'b0;
      end else if (sleep_instruction) begin
        core_status_flags[mor_pkg::ST_TO] <= 1'b1;
        core_status_flags[mor_pkg::ST_PD] <= 1'b0;
      end else if (watchdog_clear_instruction) begin
        core_status_flags[mor_pkg::ST_TO] <= 1'b1;
        core_status_flags[mor_pkg::ST_PD] <= 1'b1;
      end
    end
  end

  // Page bits copied into the program counter on any PC rewrite except a return.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pc_page_bits <= 2'h0;
      pc_page_load <= 1'b0;
    end else begin
      pc_page_bits <= core_status_flags[6:5];
      pc_page_load <= pc_load & ~pc_return;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bank and indirect pointer; a plain register when not used indirectly.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      indirect_bank_pointer <= mor_pkg::RST_ZERO;
    end else if (wr_hit && addr == mor_pkg::ADDR_BANKPTR) begin
      indirect_bank_pointer <= wdata;
    end else if (bank_instr_en) begin
      indirect_bank_pointer[7:6] <= bank_instr;
    end
  end

  // Indirect access is forwarded with the 6-bit pointer address.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ext_addr  <= mor_pkg::RST_ZERO;
      ext_rd    <= 1'b0;
      ext_wr    <= 1'b0;
      ext_wdata <= mor_pkg::RST_ZERO;
      ram_bank_select <= 2'h0;
    end else begin
      ext_addr  <= {2'h0, indirect_bank_pointer[5:0]};
      ext_rd    <= rd_en & indirect;
      ext_wr    <= wr_en & indirect;
      ext_wdata <= wdata;
      ram_bank_select <= indirect_bank_pointer[7:6];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port data latches and the control page bit.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port5_data_page_select <= mor_pkg::RST_ZERO;
      port6_data <= mor_pkg::RST_ZERO;
      port7_data <= mor_pkg::RST_ZERO;
      port8_data <= mor_pkg::RST_ZERO;
    end else if (wr_hit) begin
      unique case (addr)
        mor_pkg::ADDR_PORT5: port5_data_page_select
          <= wdata & mor_pkg::MASK_PORT5;
        mor_pkg::ADDR_PORT6: port6_data <= wdata;
        mor_pkg::ADDR_PORT7: port7_data <= wdata;
        mor_pkg::ADDR_PORT8: port8_data <= wdata;
        default: ;
      endcase
    end
  end

  // Drive enables follow the direction controls; 0 there means output.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port5_out <= 4'h0;
      port5_oe  <= 4'h0;
      port6_out <= 8'h00;
      port6_oe  <= 8'h00;
      port7_out <= 8'h00;
      port7_oe  <= 8'h00;
      port8_out <= 8'h00;
      port8_oe  <= 8'h00;
      control_page_select <= 1'b0;
    end else begin
      port5_out <= port5_data_page_select[7:4];
      port5_oe  <= ~port5_direction_control;
      port6_out <= port6_data;
      port6_oe  <= ~port6_direction_control;
      port7_out <= port7_data;
      port7_oe  <= ~port7_direction_control;
      port8_out <= port8_data;
      port8_oe  <= ~port8_direction_control;
      control_page_select <= port5_data_page_select[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Display control, segment address and counter enables.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      display_control <= mor_pkg::RST_ZERO;
      display_segment_address <= mor_pkg::RST_ZERO;
      counter_enables <= mor_pkg::RST_ZERO;
    end else if (wr_hit) begin
      unique case (addr)
        mor_pkg::ADDR_DISPCTL: display_control
          <= wdata & mor_pkg::MASK_DISPCTL;
        mor_pkg::ADDR_SEGADDR: display_segment_address
          <= wdata & mor_pkg::MASK_SEGADDR;
        mor_pkg::ADDR_CNTEN: counter_enables
          <= wdata & mor_pkg::MASK_CNTEN;
        default: ;
      endcase
    end
  end

  // Decoded display and counter controls.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bias_select    <= 1'b0;
      duty_select    <= 2'h0;
      display_enable <= 1'b0;
      waveform_type  <= 1'b0;
      frame_divisor  <= 10'h000;
      scan_data      <= 4'h0;
      {low_pulse_timer_enable, high_pulse_timer_enable,
       counter_two_enable, counter_one_enable} <= 4'h0;
    end else begin
      bias_select    <= display_control[7];
      duty_select    <= display_control[6]
        ? 2'(mor_pkg::MOR_DUTY_QUARTER)
        : {1'b0, display_control[5]};
      display_enable <= display_control[4];
      waveform_type  <= display_control[2];
      frame_divisor  <= {1'b0,
        frame_base(display_control[1:0], display_control[6]
          ? 2'(mor_pkg::MOR_DUTY_QUARTER)
          : {1'b0, display_control[5]})};
      // Disabled display grounds the segment data.
      scan_data <= display_control[4] ? seg_rdata : 4'h0;
      {low_pulse_timer_enable, high_pulse_timer_enable,
       counter_two_enable, counter_one_enable}
        <= counter_enables[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Display memory; core writes land at the segment address.
  mor_seg_ram #(
    .WIDTH (4),
    .DEPTH (32),
    .AW    (5)
  ) u_seg_ram (
    .core_clk (core_clk),
    .we       (wr_hit && addr == mor_pkg::ADDR_SEGDATA),
    .waddr    (display_segment_address[4:0]),
    .wdata    (wdata[3:0]),
    .raddr    (rd_local && addr == mor_pkg::ADDR_SEGDATA
               ? display_segment_address[4:0] : scan_addr),
    .rdata    (seg_rdata)
  );

  // Read mux; the display word is read one cycle later from the memory.
  always_comb begin
    next_rdata = mor_pkg::RST_ZERO;
    unique case (addr)
      mor_pkg::ADDR_STATUS:  next_rdata = core_status_flags
                                          & mor_pkg::MASK_STATUS;
      mor_pkg::ADDR_BANKPTR: next_rdata = indirect_bank_pointer;
      mor_pkg::ADDR_PORT5:   next_rdata = port_read(
        port5_data_page_select, port5_pins,
        {port5_direction_control, 4'h0}) & mor_pkg::MASK_PORT5;
      mor_pkg::ADDR_PORT6:   next_rdata = port_read(port6_data, port6_pins,
                                          port6_direction_control);
      mor_pkg::ADDR_PORT7:   next_rdata = port_read(port7_data, port7_pins,
                                          port7_direction_control);
      mor_pkg::ADDR_PORT8:   next_rdata = port_read(port8_data, port8_pins,
                                          port8_direction_control);
      mor_pkg::ADDR_DISPCTL: next_rdata = display_control;
      mor_pkg::ADDR_SEGADDR: next_rdata = display_segment_address;
      mor_pkg::ADDR_CNTEN:   next_rdata = counter_enables;
      default:               next_rdata = mor_pkg::RST_ZERO;
    endcase
  end

  // Registered read data; indirect reads return the banked RAM word.
  logic seg_rd_q;
  logic ind_rd_q;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      seg_rd_q <= 1'b0;
      ind_rd_q <= 1'b0;
      rdata    <= mor_pkg::RST_ZERO;
    end else begin
      seg_rd_q <= rd_local && addr == mor_pkg::ADDR_SEGDATA;
      ind_rd_q <= rd_en & indirect;
      if (seg_rd_q) begin
        rdata <= {4'h0, seg_rdata};
      end else if (ind_rd_q) begin
        rdata <= ext_rdata;
      end else if (rd_local) begin
        rdata <= next_rdata;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/mor_pkg.sv */
// Purpose: Shared constants for the operational register bank.
// Assumes: Register file addresses are 8 bits wide.
// Notes:   Register offsets, status field positions and shared reset constants live here.
package mor_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_INDIRECT = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h03;
  localparam logic [7:0] ADDR_BANKPTR  = 8'h04;
  localparam logic [7:0] ADDR_PORT5    = 8'h05;
  localparam logic [7:0] ADDR_PORT6    = 8'h06;
  localparam logic [7:0] ADDR_PORT7    = 8'h07;
  localparam logic [7:0] ADDR_PORT8    = 8'h08;
  localparam logic [7:0] ADDR_DISPCTL  = 8'h09;
  localparam logic [7:0] ADDR_SEGADDR  = 8'h0A;
  localparam logic [7:0] ADDR_SEGDATA  = 8'h0B;
  localparam logic [7:0] ADDR_CNTEN    = 8'h0C;

  // Status field positions.
  localparam int ST_PAGE_LO = 5;
  localparam int ST_TO      = 4;
  localparam int ST_PD      = 3;
  localparam int ST_Z       = 2;
  localparam int ST_DC      = 1;
  localparam int ST_C       = 0;

  // Write and read masks; unused bits read zero.
  localparam logic [7:0] MASK_STATUS  = 8'h7F;
  localparam logic [7:0] MASK_STATUS_SW = 8'h67;
  localparam logic [7:0] MASK_PORT5   = 8'hF1;
  localparam logic [7:0] MASK_DISPCTL = 8'hF7;
  localparam logic [7:0] MASK_SEGADDR = 8'h1F;
  localparam logic [7:0] MASK_SEGDATA = 8'h0F;
  localparam logic [7:0] MASK_CNTEN   = 8'h0F;

  // Reset values.
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [1:0] RST_FLAGS    = 2'h3;

  // Frame divisor base counts, indexed by duty then frame rate.
  localparam logic [8:0] DIV_H0 = 9'h100;
  localparam logic [8:0] DIV_H1 = 9'h118;
  localparam logic [8:0] DIV_H2 = 9'h130;
  localparam logic [8:0] DIV_H3 = 9'h0E8;
  localparam logic [8:0] DIV_T0 = 9'h0AC;
  localparam logic [8:0] DIV_T1 = 9'h0BC;
  localparam logic [8:0] DIV_T2 = 9'h0CC;
  localparam logic [8:0] DIV_T3 = 9'h09C;
  localparam logic [8:0] DIV_Q0 = 9'h080;
  localparam logic [8:0] DIV_Q1 = 9'h08C;
  localparam logic [8:0] DIV_Q2 = 9'h098;
  localparam logic [8:0] DIV_Q3 = 9'h074;

  // Duty codes.
  typedef enum logic [1:0] {
    MOR_DUTY_HALF,
    MOR_DUTY_THIRD,
    MOR_DUTY_QUARTER
  } mor_duty_t;

endpackage

/* File: rtl/mor_seg_ram.sv */
// Purpose: Segment display memory, 32 words of 4 bits.
// Assumes: One write and one read port on the core clock.
// Notes:   Read data comes out of a register.
`timescale 1ns/1ps
`default_nettype none
module mor_seg_ram #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             core_clk, // Core clock.
  input  wire logic             we,       // Write strobe.
  input  wire logic [AW-1:0]    waddr,    // Write address.
  input  wire logic [WIDTH-1:0] wdata,    // Write data.
  input  wire logic [AW-1:0]    raddr,    // Read address.
  output logic      [WIDTH-1:0] rdata     // Registered read data.
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Store on write, register the read word every cycle.
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

/* File: verification/mor_chk_sva.sv */
// Purpose: Port checks for the operational register bank.
// Assumes: Bound to mor_regs; outputs are registered.
// Notes:   Counter selects are driven only by writes; bank selects also by BANK instructions.
`timescale 1ns/1ps
`default_nettype none
module mor_chk (
  input wire logic       core_clk,                // Clock.
  input wire logic       resetn,                  // Reset, active low.
  input wire logic       wr_en,                   // Write strobe.
  input wire logic       rd_en,                   // Read strobe.
  input wire logic [7:0] addr,                    // Address.
  input wire logic [7:0] wdata,                   // Write data.
  input wire logic [7:0] ext_addr,                // Banked address.
  input wire logic       ext_rd,                  // Banked read.
  input wire logic       ext_wr,                  // Banked write.
  input wire logic       pc_load,                 // Program jump.
  input wire logic       pc_return,               // Return.
  input wire logic       pc_page_load,            // Page load pulse.
  input wire logic [1:0] ram_bank_select,         // Data bank.
  input wire logic [7:0] port6_direction_control, // Direction.
  input wire logic [7:0] port6_oe,                // Drive enables.
  input wire logic       display_enable,          // Display on.
  input wire logic [3:0] scan_data,               // Segment data.
  input wire logic       bias_select,             // Bias.
  input wire logic       waveform_type,           // Waveform.
  input wire logic       counter_one_enable,      // Counter 1.
  input wire logic       low_pulse_timer_enable   // Low timer.
);
  // All checks share the core clock and its reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_page_load: assert property (pc_load && !pc_return |=> pc_page_load)
    else $error("Page load pulse missing.");
  chk_return_keeps: assert property (pc_return |=> !pc_page_load)
    else $error("Return loaded the page.");
  chk_ext_write: assert property (wr_en && addr == 8'h00 |=> ext_wr && ext_addr[7:6] == 2'b00)
    else $error("Indirect write not forwarded.");
  chk_ext_read: assert property (rd_en && addr == 8'h00 |=> ext_rd)
    else $error("Indirect read not forwarded.");
  chk_no_stray: assert property (!(wr_en && addr == 8'h00) |=> !ext_wr)
    else $error("Banked write without cause.");
  chk_bank_follow: assert property (wr_en && addr == 8'h04 |=> ##1 ram_bank_select == $past(wdata[7:6], 2))
    else $error("Bank select wrong.");
  chk_oe_follow: assert property ($past(resetn) |-> port6_oe == ~$past(port6_direction_control))
    else $error("Drive enable wrong.");
  chk_display_fields: assert property (wr_en && addr == 8'h09 |=> ##1 bias_select == $past(wdata[7], 2) && waveform_type == $past(wdata[2], 2))
    else $error("Display field wrong.");
  chk_counter_bits: assert property (wr_en && addr == 8'h0C |=> ##1 counter_one_enable == $past(wdata[0], 2) && low_pulse_timer_enable == $past(wdata[3], 2))
    else $error("Counter enable wrong.");
  chk_blank_off: assert property (!display_enable [*3] |-> scan_data == 4'h0)
    else $error("Segment data while disabled.");
endmodule
bind mor_regs mor_chk u_chk (.core_clk, .resetn, .wr_en, .rd_en, .addr,
  .wdata, .ext_addr, .ext_rd, .ext_wr, .pc_load, .pc_return, .pc_page_load,
  .ram_bank_select, .port6_direction_control, .port6_oe, .display_enable,
  .scan_data, .bias_select, .waveform_type, .counter_one_enable,
  .low_pulse_timer_enable);
`default_nettype wire

/* File: verification/mcu_operational_registers_bench.sv */
// Purpose: Self-checking bench for the operational register bank.
// Assumes: One access per call; reads wait out the longest latency.
// Notes:   Pins and directions are random in the background.
`timescale 1ns/1ps
`default_nettype none
module mcu_operational_registers_bench;
  logic       core_clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, ext_rdata = 8'h00;
  logic [7:0] port5_pins = 8'h00, port6_pins = 8'h00, port7_pins = 8'h00;
  logic [7:0] port8_pins = 8'h00, port6_direction_control = 8'h00;
  logic [7:0] port7_direction_control = 8'h00;
  logic [7:0] port8_direction_control = 8'h00;
  logic [3:0] port5_direction_control = 4'h0;
  logic [2:0] alu_flags = 3'h0;
  logic [1:0] page_instr = 2'h0, bank_instr = 2'h0;
  logic [4:0] scan_addr = 5'h00;
  logic [9:0] ev = 10'h000;
  wire  [7:0] rdata, ext_addr, ext_wdata, port6_out;
  wire  [9:0] frame_divisor;
  wire  [1:0] pc_page_bits, ram_bank_select, duty_select;
  wire  [3:0] scan_data;
  wire        ext_wr, pc_page_load;
  int         fails = 0, comparisons = 0, seed = 10275;
  logic [7:0] a, d, e, g;
  logic [7:0] aset [7] = '{8'h03, 8'h04, 8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h0F};
  int         evi [6] = '{2, 4, 3, 4, 1, 0};
  int         tp [6] = '{8'h10, 8'h00, 8'h18, 8'h08, 8'h10, 8'h18};
  int dv [12] = '{256, 280, 304, 232, 172, 188, 204, 156, 128, 140, 152, 116};

  mor_regs dut (.core_clk, .resetn, .power_up(ev[0]), .reset_pin_wake(ev[1]),
    .wr_en, .rd_en, .addr, .wdata, .rdata, .ext_addr, .ext_rd(), .ext_wr,
    .ext_wdata, .ext_rdata, .alu_we(ev[7]), .alu_flags,
    .sleep_instruction(ev[2]), .watchdog_clear_instruction(ev[3]),
    .watchdog_timeout(ev[4]), .pc_load(ev[5]), .pc_return(ev[6]),
    .page_instr, .page_instr_en(ev[8]), .bank_instr, .bank_instr_en(ev[9]),
    .pc_page_bits, .pc_page_load, .ram_bank_select, .port5_pins, .port6_pins,
    .port7_pins, .port8_pins, .port5_direction_control,
    .port6_direction_control, .port7_direction_control,
    .port8_direction_control, .port5_out(), .port5_oe(), .port6_out,
    .port6_oe(), .port7_out(), .port7_oe(), .port8_out(), .port8_oe(),
    .control_page_select(), .bias_select(), .duty_select, .display_enable(),
    .waveform_type(), .frame_divisor, .low_pulse_timer_enable(),
    .high_pulse_timer_enable(), .counter_two_enable(),
    .counter_one_enable(), .scan_addr, .scan_data);

  // Clock generation.
  initial forever #4 core_clk = ~core_clk;
  // Background randomness on pins, directions and unused operands.
  always @(posedge core_clk) begin
    {port5_pins, port6_pins, port7_pins, port8_pins} <= $random(seed);
    {port5_direction_control, port6_direction_control,
     port7_direction_control, port8_direction_control} <= 28'($random(seed));
    {alu_flags, page_instr, bank_instr} <= 7'($random(seed));
  end
  // Hang guard.
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    give_verdict();
  end

  function automatic logic [7:0] msk(input logic [7:0] ra);
    case (ra)
      8'h03: msk = 8'h67;
      8'h04: msk = 8'hFF;
      8'h09: msk = 8'hF7;
      8'h0A: msk = 8'h1F;
      8'h0C: msk = 8'h0F;
      default: msk = 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ta, input logic [7:0] td);
    @(posedge core_clk);
    wr_en <= 1'b1; addr <= ta; wdata <= td;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ta, output logic [7:0] q);
    @(posedge core_clk);
    rd_en <= 1'b1; addr <= ta;
    @(posedge core_clk);
    rd_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 q = rdata;
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    ev[k] <= 1'b1;
    @(posedge core_clk);
    ev <= 10'h000;
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rd(8'h03, g); chk(g, 8'h18);
    for (int i = 0; i < 40; i++) begin
      a = aset[i % 7];
      d = 8'($random(seed));
      if (a == 8'h0C) d = d & 8'h5F;
      wr(a, d); rd(a, g);
      chk(g, (d & msk(a)) | ((a == 8'h03) ? 8'h18 : 8'h00));
    end
    wr(8'h06, 8'hA5); @(posedge core_clk); #1 chk(port6_out, 8'hA5);
    for (int i = 0; i < 6; i++) begin
      pulse(evi[i]); rd(8'h03, g); chk(g & 8'h18, tp[i]);
    end
    // Strobed operands are read at the edge that the design samples them.
    pulse(7); e = 8'(alu_flags); rd(8'h03, g);
    chk(g & 8'h07, e);
    pulse(8); e = {1'b0, page_instr, 5'h00}; rd(8'h03, g);
    chk(g & 8'h60, e);
    pulse(9); e = {bank_instr, 6'h00}; rd(8'h04, g);
    chk(g & 8'hC0, e);
    wr(8'h03, 8'h40); pulse(5); #1 chk(pc_page_load, 1);
    chk(pc_page_bits, 2);
    pulse(6); #1 chk(pc_page_load, 0);
    for (int m = 0; m < 12; m++) begin
      d = {1'b0, (m < 4) ? 2'd0 : (m < 8) ? 2'd1 : 2'd3, 3'b100, 2'(m % 4)};
      wr(8'h09, d); @(posedge core_clk); #1 chk(frame_divisor, dv[m]);
      chk(duty_select, m / 4);
    end
    for (int i = 0; i < 4; i++) begin
      a = 8'($random(seed)) & 8'h1F;
      d = 8'($random(seed)) & 8'h0F;
      wr(8'h0A, a); wr(8'h0B, d | 8'hF0); rd(8'h0B, g); chk(g, d);
      @(posedge core_clk); scan_addr <= a[4:0];
      repeat (3) @(posedge core_clk); #1 chk(scan_data, d);
    end
    wr(8'h09, 8'h00); repeat (4) @(posedge core_clk); #1 chk(scan_data, 0);
    wr(8'h04, 8'hC5); wr(8'h00, 8'h3C); #1 chk(ext_wr, 1);
    chk(ext_addr, 8'h05); chk(ext_wdata, 8'h3C);
    chk(ram_bank_select, 3);
    e = 8'($random(seed));
    @(posedge core_clk); ext_rdata <= e;
    rd(8'h00, g); chk(g, e);
    give_verdict();
  end
endmodule
`default_nettype wire
